// ### npec_regs.vh
// constants for the nand command-interface host controller
// assumes a 50 MHz core clock and a device with no clock of its own
`ifndef NPEC_REGS_VH
`define NPEC_REGS_VH
`define NPEC_CMD_READ_A 8'h00
`define NPEC_CMD_READ_B 8'h01
`define NPEC_CMD_READ_C 8'h50
`define NPEC_CMD_PROG 8'h80
`define NPEC_CMD_PROG_GO 8'h10
`define NPEC_CMD_ERASE 8'h60
`define NPEC_CMD_ERASE_GO 8'hd0
`define NPEC_CMD_STATUS 8'h70
`define NPEC_CMD_ID 8'h90
`define NPEC_CMD_RESET 8'hff
`define NPEC_ID_ADDR 8'h00
`define NPEC_PAGE_BYTES 10'd528
`define NPEC_MAIN_PARTIAL_MAX 2'd2
`define NPEC_SPARE_PARTIAL_MAX 2'd3
`define NPEC_ST_FAIL_BIT 0
`define NPEC_ST_READY_BIT 6
`define NPEC_ST_UNPROT_BIT 7
`define NPEC_ST_RESET_VAL 8'hc0
`define NPEC_OP_PROG 3'd1
`define NPEC_OP_ERASE 3'd2
`define NPEC_OP_STATUS 3'd3
`define NPEC_OP_ID 3'd4
`define NPEC_OP_RESET 3'd5
`define NPEC_OP_POINTER 3'd6
// strobe timing: each strobe phase except the read high phase, in ns and in cycles (rounded up)
`define NPEC_T_PHASE_NS 30
`define NPEC_T_PHASE_CYC 4'd2
`endif

// ### npec_skid.v
// two-entry buffer between the user read path and the device read data
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module npec_skid (
	input wire clk,
	input wire rst,
	input wire [7:0] i_data,
	input wire i_valid,
	output wire o_ready,
	output wire [7:0] o_data,
	output wire o_valid,
	input wire i_ready
);
	reg [7:0] mem_q [0:1];
	reg rd_q;
	reg wr_q;
	reg [1:0] cnt_q;
	wire push;
	wire pop;
	assign push = i_valid && (cnt_q != 2'd2);
	assign pop = (cnt_q != 2'd0) && i_ready;
	assign o_ready = (cnt_q != 2'd2);
	assign o_valid = (cnt_q != 2'd0);
	assign o_data = mem_q[rd_q];
	// pointers and fill count; honest full at two entries
	always @(posedge clk) begin
		if (rst) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			cnt_q <= 2'd0;
		end else begin
			if (push) begin
				mem_q[wr_q] <= i_data;
				wr_q <= ~wr_q;
			end
			if (pop)
				rd_q <= ~rd_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // npec_skid
`default_nettype wire

// ### npec_host.v
// host controller driving a nand card through its strobes and byte bus
// assumes pins synchronous to I_CORE_CLK; ready/busy pulled up outside
`timescale 1ns/1ps
`default_nettype none
`include "npec_regs.vh"
module npec_host (
	input wire I_CORE_CLK,
	input wire I_RESET,
	input wire I_CMD_VALID,
	input wire [2:0] I_CMD_OP,
	input wire [7:0] I_CMD_ARG,
	input wire [23:0] I_CMD_ADDR,
	input wire [9:0] I_CMD_LEN,
	input wire I_CMD_PROTECT,
	output reg O_CMD_READY,
	input wire I_WR_VALID,
	input wire [7:0] I_WR_DATA,
	output reg O_WR_READY,
	output reg O_RD_VALID,
	output reg [7:0] O_RD_DATA,
	input wire I_RD_READY,
	output reg O_DONE,
	output reg O_FAIL,
	output reg O_LIMIT_ERR,
	output reg O_CHIP_SEL_N,
	output reg O_CMD_LATCH,
	output reg O_ADDR_LATCH,
	output reg O_INPUT_STROBE_N,
	output reg O_OUTPUT_STROBE_N,
	output reg O_PROTECT_N,
	input wire [7:0] I_IO,
	output reg [7:0] O_IO,
	output reg O_IO_OE,
	input wire I_READY_BUSY_N
);
	localparam S_IDLE = 7'b0000001;
	localparam S_SEQ = 7'b0000010; // emit the byte list
	localparam S_DATA = 7'b0000100; // serial program data
	localparam S_WAIT = 7'b0001000; // wait for ready/busy high
	localparam S_POLL = 7'b0010000; // status read cycle
	localparam S_READ = 7'b0100000; // status or id read cycles
	localparam S_END = 7'b1000000;

	reg [6:0] st_q;
	reg [7:0] seq_q [0:4]; // byte list: command then addresses then confirm
	reg [4:0] kind_q; // per entry: 1 = command, 0 = address
	reg [2:0] n_q;
	reg [2:0] idx_q;
	reg [2:0] op_q;
	reg [9:0] left_q;
	reg [3:0] ph_q; // strobe phase counter
	reg [1:0] step_q; // reads: 0 low phase, 1 high phase; writes: 0 high phase, 1 low phase
	reg [1:0] rdn_q;
	reg loaded_q;
	reg [1:0] part_q; // partial programs since last erase, whole device
	reg area_spare_q;
	reg rb_low_q; // saw ready/busy fall
	reg [7:0] rd_byte_q; // byte sampled while the read strobe is low
	wire sk_ready;
	wire sk_valid;
	wire [7:0] sk_data;
	reg sk_push;
	wire ph_done;
	wire sk_take;
	wire [1:0] part_max;
	integer i;

	assign ph_done = (ph_q == `NPEC_T_PHASE_CYC - 4'd1);
	assign part_max = area_spare_q ? `NPEC_SPARE_PARTIAL_MAX
		: `NPEC_MAIN_PARTIAL_MAX;
	assign sk_take = !O_RD_VALID || I_RD_READY;

	// read data passes a two-entry buffer so a stalled user drops nothing
	npec_skid u_skid (
		.clk(I_CORE_CLK),
		.rst(I_RESET),
		.i_data(rd_byte_q),
		.i_valid(sk_push),
		.o_ready(sk_ready),
		.o_data(sk_data),
		.o_valid(sk_valid),
		.i_ready(sk_take)
	);
	// output stage: refill when empty or when the user takes the byte
	always @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			O_RD_VALID <= 1'b0;
			O_RD_DATA <= 8'h00;
		end else if (sk_take) begin
			O_RD_VALID <= sk_valid;
			if (sk_valid)
				O_RD_DATA <= sk_data;
		end
	end

	// main sequencer
	always @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			st_q <= S_IDLE;
			for (i = 0; i < 5; i = i + 1)
				seq_q[i] <= 8'h00;
			kind_q <= 5'd0;
			n_q <= 3'd0;
			idx_q <= 3'd0;
			op_q <= 3'd0;
			left_q <= 10'd0;
			ph_q <= 4'd0;
			step_q <= 2'd0;
			rdn_q <= 2'd0;
			loaded_q <= 1'b0;
			part_q <= 2'd0;
			area_spare_q <= 1'b0;
			rb_low_q <= 1'b0;
			rd_byte_q <= 8'h00;
			sk_push <= 1'b0;
			O_CMD_READY <= 1'b0;
			O_WR_READY <= 1'b0;
			O_DONE <= 1'b0;
			O_FAIL <= 1'b0;
			O_LIMIT_ERR <= 1'b0;
			O_CHIP_SEL_N <= 1'b1;
			O_CMD_LATCH <= 1'b0;
			O_ADDR_LATCH <= 1'b0;
			O_INPUT_STROBE_N <= 1'b1;
			O_OUTPUT_STROBE_N <= 1'b1;
			O_PROTECT_N <= 1'b0;
			O_IO <= 8'h00;
			O_IO_OE <= 1'b0;
		end else begin
			sk_push <= 1'b0;
			O_DONE <= 1'b0;
			O_LIMIT_ERR <= 1'b0;
			O_WR_READY <= 1'b0;
			O_PROTECT_N <= ~I_CMD_PROTECT; // two-step protect, pin side
			case (st_q)
			S_IDLE: begin
				O_CMD_READY <= 1'b1;
				O_CHIP_SEL_N <= 1'b1;
				O_IO_OE <= 1'b0;
				idx_q <= 3'd0;
				step_q <= 2'd0;
				ph_q <= 4'd0;
				rb_low_q <= 1'b0;
				rdn_q <= 2'd0;
				loaded_q <= 1'b0;
				if (I_CMD_VALID && O_CMD_READY) begin
					O_CMD_READY <= 1'b0;
					op_q <= I_CMD_OP;
					left_q <= (I_CMD_LEN > `NPEC_PAGE_BYTES)
						? `NPEC_PAGE_BYTES : I_CMD_LEN;
					st_q <= S_SEQ;
					O_CHIP_SEL_N <= 1'b0;
					case (I_CMD_OP)
					`NPEC_OP_PROG: begin
						// refuse a program past the device-wide partial limit
						if (part_q >= part_max) begin
							O_LIMIT_ERR <= 1'b1;
							O_CMD_READY <= 1'b1;
							O_CHIP_SEL_N <= 1'b1;
							st_q <= S_IDLE;
						end
						seq_q[0] <= `NPEC_CMD_PROG;
						seq_q[1] <= I_CMD_ADDR[7:0];
						seq_q[2] <= I_CMD_ADDR[15:8];
						seq_q[3] <= I_CMD_ADDR[23:16];
						kind_q <= 5'b00001;
						n_q <= 3'd4;
					end
					`NPEC_OP_ERASE: begin
						// block address: only upper row bits matter
						seq_q[0] <= `NPEC_CMD_ERASE;
						seq_q[1] <= I_CMD_ADDR[15:8];
						seq_q[2] <= I_CMD_ADDR[23:16];
						seq_q[3] <= `NPEC_CMD_ERASE_GO;
						kind_q <= 5'b01001;
						n_q <= 3'd4;
					end
					`NPEC_OP_STATUS: begin
						seq_q[0] <= `NPEC_CMD_STATUS;
						kind_q <= 5'b00001;
						n_q <= 3'd1;
					end
					`NPEC_OP_ID: begin
						seq_q[0] <= `NPEC_CMD_ID;
						seq_q[1] <= `NPEC_ID_ADDR;
						kind_q <= 5'b00001;
						n_q <= 3'd2;
					end
					`NPEC_OP_RESET: begin
						seq_q[0] <= `NPEC_CMD_RESET;
						kind_q <= 5'b00001;
						n_q <= 3'd1;
					end
					default: begin
						// pointer: 00h, 01h or 50h from the argument
						seq_q[0] <= I_CMD_ARG;
						area_spare_q <= (I_CMD_ARG == `NPEC_CMD_READ_C);
						kind_q <= 5'b00001;
						n_q <= 3'd1;
					end
					endcase
				end
			end
			S_SEQ, S_DATA: begin
				// one write cycle: strobe low phase, then rise latches
				O_IO_OE <= 1'b1;
				O_CMD_LATCH <= (st_q == S_SEQ) && kind_q[idx_q];
				O_ADDR_LATCH <= (st_q == S_SEQ) && !kind_q[idx_q];
				if (st_q == S_SEQ)
					O_IO <= seq_q[idx_q];
				ph_q <= ph_q + 4'd1;
				if (step_q == 2'd0) begin
					if (st_q == S_DATA && !I_WR_VALID)
						ph_q <= 4'd0; // user stall holds the strobe high
					else if (ph_done) begin
						O_INPUT_STROBE_N <= 1'b0;
						if (st_q == S_DATA) begin
							O_IO <= I_WR_DATA;
							O_WR_READY <= 1'b1;
						end
						step_q <= 2'd1;
						ph_q <= 4'd0;
					end
				end else if (ph_done) begin
					O_INPUT_STROBE_N <= 1'b1;
					step_q <= 2'd0;
					ph_q <= 4'd0;
					if (st_q == S_DATA) begin
						loaded_q <= 1'b1;
						left_q <= left_q - 10'd1;
						if (left_q == 10'd1) begin
							// confirm goes out only after data
							seq_q[0] <= `NPEC_CMD_PROG_GO;
							n_q <= 3'd1;
							idx_q <= 3'd0;
							st_q <= S_SEQ;
						end
					end else if (idx_q == n_q - 3'd1) begin
						idx_q <= 3'd0;
						if (op_q == `NPEC_OP_PROG && !loaded_q) begin
							if (left_q == 10'd0) begin
								// nothing to load: no confirm, end quietly
								st_q <= S_END;
							end else
								st_q <= S_DATA;
						end else if (op_q == `NPEC_OP_PROG ||
							op_q == `NPEC_OP_ERASE ||
							op_q == `NPEC_OP_RESET) begin
							if (op_q == `NPEC_OP_PROG)
								part_q <= part_q + 2'd1;
							if (op_q == `NPEC_OP_ERASE)
								part_q <= 2'd0;
							st_q <= S_WAIT;
						end else if (op_q == `NPEC_OP_STATUS ||
							op_q == `NPEC_OP_ID)
							st_q <= S_READ;
						else
							st_q <= S_END;
					end else
						idx_q <= idx_q + 3'd1;
				end
			end
			S_WAIT: begin
				// only status and reset may reach the device now
				O_IO_OE <= 1'b0;
				O_CMD_LATCH <= 1'b0;
				O_ADDR_LATCH <= 1'b0;
				ph_q <= ph_q + 4'd1;
				if (!I_READY_BUSY_N)
					rb_low_q <= 1'b1;
				// high again after a fall, or no fall seen in time
				if ((rb_low_q || ph_q == 4'hf) && I_READY_BUSY_N) begin
					st_q <= (op_q == `NPEC_OP_RESET) ? S_END
						: S_POLL;
					ph_q <= 4'd0;
				end
			end
			S_POLL: begin
				// device already in status mode; read without 70h
				ph_q <= ph_q + 4'd1;
				if (step_q == 2'd0) begin
					O_OUTPUT_STROBE_N <= 1'b0;
					if (ph_done) begin
						step_q <= 2'd1;
						ph_q <= 4'd0;
					end
				end else begin
					O_OUTPUT_STROBE_N <= 1'b1;
					O_FAIL <= I_IO[`NPEC_ST_FAIL_BIT];
					// verify may still be running; poll bit 6
					if (I_IO[`NPEC_ST_READY_BIT])
						st_q <= S_END;
					step_q <= 2'd0;
					ph_q <= 4'd0;
				end
			end
			S_READ: begin
				// status or id bytes to the user
				O_IO_OE <= 1'b0;
				O_CMD_LATCH <= 1'b0;
				O_ADDR_LATCH <= 1'b0;
				ph_q <= ph_q + 4'd1;
				if (step_q == 2'd0) begin
					if (!sk_ready)
						ph_q <= 4'd0; // buffer full stalls the strobe
					else begin
						O_OUTPUT_STROBE_N <= 1'b0;
						if (ph_done) begin
							step_q <= 2'd1;
							ph_q <= 4'd0;
						end
					end
				end else begin
					O_OUTPUT_STROBE_N <= 1'b1;
					rd_byte_q <= I_IO; // strobe still low, bus valid
					sk_push <= 1'b1; // status or id byte into the buffer
					rdn_q <= rdn_q + 2'd1;
					step_q <= 2'd0;
					ph_q <= 4'd0;
					if (op_q == `NPEC_OP_STATUS || rdn_q == 2'd1)
						st_q <= S_END;
				end
			end
			S_END: begin
				O_IO_OE <= 1'b0;
				O_CMD_LATCH <= 1'b0;
				O_ADDR_LATCH <= 1'b0;
				O_CHIP_SEL_N <= 1'b1;
				O_DONE <= 1'b1;
				st_q <= S_IDLE;
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end
endmodule // npec_host
`default_nettype wire

// ### npec_host_checker.sv
// checker for the nand host strobes, latches and byte bus
// assumes it is bound to npec_host with one clock and sync reset
`timescale 1ns/1ps
`default_nettype none
module npec_host_checker (
	input wire logic I_CORE_CLK,
	input wire logic I_RESET,
	input wire logic I_CMD_PROTECT,
	input wire logic O_CMD_READY,
	input wire logic O_DONE,
	input wire logic O_LIMIT_ERR,
	input wire logic O_CHIP_SEL_N,
	input wire logic O_CMD_LATCH,
	input wire logic O_ADDR_LATCH,
	input wire logic O_INPUT_STROBE_N,
	input wire logic O_OUTPUT_STROBE_N,
	input wire logic O_PROTECT_N,
	input wire logic [7:0] O_IO,
	input wire logic O_IO_OE
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RESET);
	// a strobe stays low two cycles, then goes high
	sequence s_low2(s);
		!s ##1 !s ##1 s;
	endsequence
	// a refused command leaves the bus idle on its edge and the one before;
	// the next command may legally start right after the refusal
	sequence s_quiet;
		O_CHIP_SEL_N && O_INPUT_STROBE_N && $past(O_CHIP_SEL_N)
			&& $past(O_INPUT_STROBE_N);
	endsequence
	a_wr_phase: assert property ($fell(O_INPUT_STROBE_N) |-> s_low2(O_INPUT_STROBE_N))
		else $error("write strobe phase wrong");
	a_rd_phase: assert property ($fell(O_OUTPUT_STROBE_N) |-> s_low2(O_OUTPUT_STROBE_N))
		else $error("read strobe phase wrong");
	a_latch_excl: assert property (!(O_CMD_LATCH && O_ADDR_LATCH))
		else $error("both latches high");
	a_latch_sel: assert property (O_CMD_LATCH || O_ADDR_LATCH |-> !O_CHIP_SEL_N)
		else $error("latch without select");
	a_write_drive: assert property (!O_INPUT_STROBE_N |-> O_IO_OE)
		else $error("bus not driven in write");
	a_data_hold: assert property ($rose(O_INPUT_STROBE_N) |-> $stable(O_IO))
		else $error("write byte moved");
	a_read_free: assert property (!O_OUTPUT_STROBE_N |-> !O_IO_OE)
		else $error("bus driven in read");
	a_limit_quiet: assert property (O_LIMIT_ERR |-> s_quiet)
		else $error("bus active on refusal");
	a_done_pulse: assert property (O_DONE |=> !O_DONE)
		else $error("done longer than a cycle");
	a_protect_map: assert property (!$past(I_RESET) |-> O_PROTECT_N == !$past(I_CMD_PROTECT))
		else $error("protect pin wrong");
	a_reset_idle: assert property ($fell(I_RESET) |-> O_CHIP_SEL_N && !O_CMD_READY ##1 O_CMD_READY)
		else $error("release from reset wrong");
endmodule // npec_host_checker
bind npec_host npec_host_checker u_chk (.I_CORE_CLK, .I_RESET, .I_CMD_PROTECT,
	.O_CMD_READY, .O_DONE, .O_LIMIT_ERR, .O_CHIP_SEL_N, .O_CMD_LATCH,
	.O_ADDR_LATCH, .O_INPUT_STROBE_N, .O_OUTPUT_STROBE_N, .O_PROTECT_N,
	.O_IO, .O_IO_OE);
`default_nettype wire

// ### npec_dev_model.sv
// behavioural nand card answering the host strobes and byte bus
// assumes the host drives all strobes; ready/busy has a pull-up
`timescale 1ns/1ps
`default_nettype none
module npec_dev_model #(
	parameter logic [7:0] MAKER_CODE = 8'h3a, // arbitrary value
	parameter logic [7:0] PART_CODE = 8'h5c // arbitrary value
) (
	input wire logic cs_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic wp_n,
	input wire logic io_oe,
	input wire logic [7:0] io_host,
	input wire logic fail_next,
	input wire logic [15:0] busy_ns,
	output logic [7:0] io_in,
	output logic rb_n
);
	logic [7:0] ptr = 8'h00, last = 8'h00, adr[3], dq[$];
	logic [9:0] blk;
	logic fail = 0, in_rst = 0;
	int mode = 0, id_ix = 0, n_adr = 0, n_prog = 0, n_rst = 0, gen = 0;
	initial rb_n = 1;
	// busy for a while; a later busy command supersedes the pending end
	task automatic go_busy(int d);
		int g;
		gen++;
		g = gen;
		rb_n = 0;
		fork
			begin
				#(d);
				if (g == gen) rb_n = 1;
			end
		join_none
	endtask
	// bytes latch on the rising input strobe
	always @(posedge we_n) if (!cs_n) begin
		if (cle && (rb_n || io_host inside {8'h70, 8'hff})) begin
			if (io_host != 8'hff) in_rst = 0;
			case (io_host)
			8'h80, 8'h60: begin
				n_adr = 0;
				dq.delete();
			end
			8'h10: if (dq.size() > 0) begin
				go_busy(busy_ns);
				fail = fail_next;
				n_prog++;
				mode = 1;
			end
			8'hd0: begin
				go_busy(busy_ns);
				blk = {adr[1][5:0], adr[0][7:4]};
				mode = 1;
			end
			8'h70: mode = 1;
			8'h90: begin
				mode = 2;
				id_ix = 0;
			end
			8'hff: if (!in_rst) begin
				go_busy(100);
				in_rst = 1;
				fail = 0;
				n_rst++;
				mode = 0;
			end
			default: begin
				ptr = io_host;
				mode = 0;
			end
			endcase
		end else if (ale) begin
			adr[n_adr % 3] = io_host;
			n_adr++;
		end else if (!cle) dq.push_back(io_host);
	end
	// status is live, so polling needs no strobe toggle
	wire [7:0] st = {wp_n, rb_n, 5'h00, fail};
	wire [7:0] dout = mode == 2 ? (id_ix == 0 ? MAKER_CODE : PART_CODE)
		: mode == 1 ? st : ~last;
	// step the identity byte on each read
	always @(posedge re_n) if (!cs_n) begin
		last = dout;
		if (mode == 2) id_ix++;
	end
	// released bus shows the inverse of the last byte, never a guess
	always @* io_in = io_oe ? io_host : !cs_n && !re_n ? dout : ~last;
endmodule // npec_dev_model
`default_nettype wire

// ### npec_host_bench.sv
// self-checking bench for the nand host controller and a card model
// assumes the checker binds itself through its own file
`timescale 1ns/1ps
`default_nettype none
module npec_host_bench;
	logic clk = 0, rst = 1, cv = 0, prot = 0, wv = 0, rr = 0, fail_next = 0;
	logic [2:0] op = 0;
	logic [7:0] arg = 0, rd_data, io_out, io_in, wbuf[528], rq[$];
	logic [23:0] adr = 0;
	logic [9:0] len = 0;
	logic [15:0] busy_ns = 40;
	wire cmd_rdy, wr_rdy, rd_v, done, fail, lim, cs_n, cle, ale;
	wire we_n, re_n, wp_n, oe, rb_n;
	int error_cnt = 0, samples_checked = 0, wi = 0;
	wire [7:0] wd = wbuf[wi];
	npec_host dut (.I_CORE_CLK(clk), .I_RESET(rst), .I_CMD_VALID(cv),
		.I_CMD_OP(op), .I_CMD_ARG(arg), .I_CMD_ADDR(adr), .I_CMD_LEN(len),
		.I_CMD_PROTECT(prot), .O_CMD_READY(cmd_rdy), .I_WR_VALID(wv),
		.I_WR_DATA(wd), .O_WR_READY(wr_rdy), .O_RD_VALID(rd_v),
		.O_RD_DATA(rd_data), .I_RD_READY(rr), .O_DONE(done), .O_FAIL(fail),
		.O_LIMIT_ERR(lim), .O_CHIP_SEL_N(cs_n), .O_CMD_LATCH(cle),
		.O_ADDR_LATCH(ale), .O_INPUT_STROBE_N(we_n),
		.O_OUTPUT_STROBE_N(re_n), .O_PROTECT_N(wp_n), .I_IO(io_in),
		.O_IO(io_out), .O_IO_OE(oe), .I_READY_BUSY_N(rb_n));
	npec_dev_model card (.cs_n(cs_n), .cle(cle), .ale(ale), .we_n(we_n),
		.re_n(re_n), .wp_n(wp_n), .io_oe(oe), .io_host(io_out),
		.fail_next(fail_next), .busy_ns(busy_ns), .io_in(io_in), .rb_n(rb_n));
	always #10 clk = ~clk;
	// step write data and collect read bytes at the sampling edge
	always @(posedge clk) begin
		if (wr_rdy && wv) wi <= wi + 1;
		if (rd_v && rr) rq.push_back(rd_data);
	end
	// receiver stalls at random to exercise the buffer
	always @(negedge clk) rr = $urandom_range(1, 0);
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one command: wait for ready, raise the request for one cycle, then wait for the end
	task automatic run(logic [2:0] o, logic [7:0] a, logic [23:0] d,
		logic [9:0] n);
		int k;
		k = 0;
		while (cmd_rdy !== 1'b1 && k < 100) begin
			@(negedge clk);
			k++;
		end
		{op, arg, adr, len} = {o, a, d, n};
		wi = 0;
		rq.delete();
		cv = 1;
		wv = o == 3'd1;
		@(negedge clk);
		cv = 0;
		k = 0;
		while (done !== 1'b1 && lim !== 1'b1 && k < 5000) begin
			@(negedge clk);
			k++;
		end
		wv = 0;
		check("completion", k < 5000, 1);
	endtask
	task automatic got(int n);
		repeat (100) if (rq.size() < n) @(negedge clk);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// guard against a hung handshake
	initial begin
		#1_000_000;
		error_cnt++;
		results();
	end
	initial begin
		int k, max, expn;
		logic [9:0] n;
		logic [7:0] pa;
		foreach (wbuf[j]) wbuf[j] = 8'h00;
		k = $urandom(37989);
		repeat (10) @(negedge clk);
		rst = 0;
		repeat (2) @(negedge clk);
		for (int p = 0; p < 2; p++) begin
			prot = p[0];
			run(3, 0, 0, 0);
			got(1);
			check("status", rq[0], {!p[0], 7'h40});
		end
		$display("status test done");
		run(4, 0, 0, 0);
		got(2);
		check("maker", rq[0], card.MAKER_CODE);
		check("part", rq[1], card.PART_CODE);
		$display("id test done");
		prot = 0;
		for (int ps = 0; ps < 2; ps++) begin
			max = ps ? 3 : 2;
			k = $urandom;
			run(2, 0, k[23:0], 0);
			check("block", card.blk, k[21:12]);
			for (int i = 0; i <= max; i++) begin
				busy_ns = i[0] ? 16'd2000 : 16'd40;
				fail_next = ps == 1 && i == 1;
				pa = ps ? 8'h50 : {7'h00, i[0]};
				run(6, pa, 0, 0);
				check("pointer", card.ptr, pa);
				n = ps == 0 && i == 0 ? 10'd528 : 10'($urandom_range(16, 1));
				for (int j = 0; j < n; j++) wbuf[j] = $urandom;
				expn = card.n_prog + (i < max);
				run(1, 0, k[23:0], n);
				check("limit", lim, i == max);
				check("programs", card.n_prog, expn);
				if (i < max) begin
					check("fail", fail, fail_next);
					check("loaded", card.dq.size(), n);
					foreach (card.dq[j]) check("data", card.dq[j], wbuf[j]);
				end
			end
			$display("program pass %0d done", ps);
		end
		k = card.n_rst;
		run(5, 0, 0, 0);
		run(5, 0, 0, 0);
		check("resets", card.n_rst, k + 1);
		run(3, 0, 0, 0);
		got(1);
		check("reset status", rq[0], 8'hc0);
		$display("reset test done");
		results();
	end
endmodule // npec_host_bench
`default_nettype wire
